// [hdl/irq_vectoring.sv]
// Purpose: Gathers six interrupt requests, applies enables, and supplies vector addresses to the core.
// Assumes: Flag sources and core share ref_clk; external request lines are already synchronous flags.
// Notes: Flags are owned by their sources; this block never clears timer 2 or serial flags.
`timescale 1ns/10ps
`default_nettype none
module irq_vectoring (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [7:0] irq_enable_reg,
    input wire logic ext0_request_flag,
    input wire logic ext1_request_flag,
    input wire logic timer0_overflow,
    input wire logic timer1_overflow,
    input wire logic timer0_clear,
    input wire logic timer1_clear,
    input wire logic timer2_overflow_flag,
    input wire logic timer2_external_flag,
    input wire irq_vec_pkg::serial_flags_t serial_flags,
    input wire logic vector_ack,
    output irq_vec_pkg::vector_req_t vector_req,
    output logic [5:0] pending,
    output logic [15:0] reset_vector,
    output logic timer0_overflow_flag,
    output logic timer1_overflow_flag,
    output logic reserved_write_seen
);
    logic state5_phase2;
    logic poll_slot;
    logic t0_req;
    logic t1_req;
    logic t0_seen;
    logic t1_seen;

    irq_phase_timer u_phase (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .slot(),
        .state2_phase2(),
        .state5_phase2(state5_phase2),
        .poll_slot(poll_slot)
    );

    // Overflows seen since the last state 5 phase 2, consumed there
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            t0_req <= 1'b0;
            t1_req <= 1'b0;
        end else if (clk_en) begin
            t0_req <= state5_phase2 ? 1'b0 : (t0_req | timer0_overflow);
            t1_req <= state5_phase2 ? 1'b0 : (t1_req | timer1_overflow);
        end
    end

    // An overflow in the state 5 phase 2 slot itself still sets the flag in this cycle
    wire t0_set = state5_phase2 && (t0_req || timer0_overflow); // [R9]
    wire t1_set = state5_phase2 && (t1_req || timer1_overflow); // [R9]

    // Set wins over a clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            timer0_overflow_flag <= 1'b0;
            timer1_overflow_flag <= 1'b0;
        end else if (clk_en) begin
            timer0_overflow_flag <= t0_set || (timer0_overflow_flag && !timer0_clear); // [R9]
            timer1_overflow_flag <= t1_set || (timer1_overflow_flag && !timer1_clear); // [R9]
        end
    end

    // Timer 0/1 flags sampled into the poll view at the poll slot, two clocks after they are set
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            t0_seen <= 1'b0;
            t1_seen <= 1'b0;
        end else if (poll_slot) begin
            t0_seen <= timer0_overflow_flag; // [R9]
            t1_seen <= timer1_overflow_flag; // [R9]
        end
    end

    wire global_on = irq_enable_reg[irq_vec_pkg::EN_GLOBAL];
    wire timer2_req = timer2_overflow_flag | timer2_external_flag; // [R5] [R6]
    wire spi_req = serial_flags.spi_done_flag & serial_flags.spi_irq_enable; // [R7]
    wire serial_req = serial_flags.uart_rx_done_flag | serial_flags.uart_tx_done_flag | spi_req; // [R7] [R8]

    // Raw requests in priority order: ext0, tmr0, ext1, tmr1, serial, tmr2
    wire [5:0] raw_req = {timer2_req, serial_req, t1_seen, ext1_request_flag, t0_seen, ext0_request_flag}; // [R1] [R10]
    wire [5:0] src_en = irq_enable_reg[5:0];
    // Serial enable also gates SPI completion through serial_req
    wire [5:0] gated = raw_req & src_en & {6{global_on}}; // [R2] [R3] [R15]

    logic [2:0] winner;
    always_comb begin
        winner = 3'h7;
        for (int i = 5; i >= 0; i--) begin
            if (gated[i]) begin
                winner = 3'(i);
            end
        end
    end

    wire [15:0] winner_addr =
        (winner == 3'h0) ? irq_vec_pkg::VEC_EXT0 : // [R12]
        (winner == 3'h1) ? irq_vec_pkg::VEC_TMR0 : // [R13]
        (winner == 3'h2) ? irq_vec_pkg::VEC_EXT1 : // [R12]
        (winner == 3'h3) ? irq_vec_pkg::VEC_TMR1 : // [R13]
        (winner == 3'h4) ? irq_vec_pkg::VEC_SER : // [R14]
        irq_vec_pkg::VEC_TMR2; // [R16]

    // Vector request is evaluated at each poll slot where none is held, and then held until acknowledged
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            vector_req <= '0;
            pending <= '0;
        end else if (clk_en) begin
            if (vector_req.valid && vector_ack) begin
                vector_req <= '0;
            end else if (poll_slot && !vector_req.valid && (gated != 6'h00)) begin
                vector_req.valid <= 1'b1;
                vector_req.source <= winner;
                vector_req.address <= winner_addr;
            end
            pending <= gated;
        end
    end

    assign reset_vector = irq_vec_pkg::VEC_RESET; // [R11]

    // Flags software writing a one into the reserved enable position
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            reserved_write_seen <= 1'b0;
        end else if (clk_en) begin
            reserved_write_seen <= irq_enable_reg[irq_vec_pkg::EN_RSVD]; // [R4]
        end
    end
endmodule : irq_vectoring
`default_nettype wire

// [hdl/irq_vec_pkg.sv]
// Purpose: Constants and carrier types for the interrupt request and vectoring block.
// Assumes: One core clock; machine cycle of twelve phase slots (six states, two phases each).
// Notes: Enable byte layout follows the interrupt enable register.
// How it works
// R1: Six vectors exist: two external pins, three timer overflows, one serial.
// R2: Each source has its own enable bit; a cleared bit blocks that source.
// R3: The global enable bit, when cleared, blocks every source at once.
// R4: Software must not write one into enable bit six; it is reserved.
// R5: Timer 2 request is overflow flag OR external flag.
// R6: Timer 2 flags are not cleared on vectoring; software clears them.
// R7: Serial request is receive-done OR transmit-done OR SPI-done when SPI enable set.
// R8: UART and SPI flags stay set on vectoring; software finds the cause.
// R9: Timer 0 and 1 flags set at state5 phase2, polled next machine cycle.
// R10: Timer 2 flag set at state2 phase2, polled in that same cycle.
// R11: Any reset source starts execution at vector address zero.
// R12: External 0 vectors to 0003H, external 1 to 0013H.
// R13: Timer 0 vectors to 000BH, timer 1 to 001BH.
// R14: Combined serial request vectors to 0023H.
// R15: SPI-done interrupts only when both SPI and serial enables are one.
// R16: Timer 2 vectors to the next eight-byte slot after serial.
package irq_vec_pkg;
    localparam int NUM_SRC = 6;
    localparam int PHASE_W = 4;
    localparam logic [PHASE_W-1:0] PHASES_PER_CYCLE = 4'hC;
    // Phase slot index: state n phase 2 is slot 2*n-1
    localparam logic [PHASE_W-1:0] SLOT_STATE2_PHASE2 = 4'h3;
    localparam logic [PHASE_W-1:0] SLOT_STATE5_PHASE2 = 4'h9;
    localparam logic [PHASE_W-1:0] SLOT_POLL = 4'hB;
    // Enable register bit positions
    localparam int EN_EXT0 = 0;
    localparam int EN_TMR0 = 1;
    localparam int EN_EXT1 = 2;
    localparam int EN_TMR1 = 3;
    localparam int EN_SER = 4;
    localparam int EN_TMR2 = 5;
    localparam int EN_RSVD = 6;
    localparam int EN_GLOBAL = 7;
    localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
    localparam logic [15:0] VEC_RESET = 16'h0000;
    localparam logic [15:0] VEC_EXT0 = 16'h0003;
    localparam logic [15:0] VEC_TMR0 = 16'h000B;
    localparam logic [15:0] VEC_EXT1 = 16'h0013;
    localparam logic [15:0] VEC_TMR1 = 16'h001B;
    localparam logic [15:0] VEC_SER = 16'h0023;
    localparam logic [15:0] VEC_SLOT = 16'h0008;
    localparam logic [15:0] VEC_TMR2 = VEC_SER + VEC_SLOT;

    typedef struct packed {
        logic uart_rx_done_flag;
        logic uart_tx_done_flag;
        logic spi_done_flag;
        logic spi_irq_enable;
    } serial_flags_t;

    typedef struct packed {
        logic valid;
        logic [2:0] source;
        logic [15:0] address;
    } vector_req_t;
endpackage : irq_vec_pkg

// [hdl/irq_phase_timer.sv]
// Purpose: Machine-cycle phase counter giving state/phase strobes.
// Assumes: Twelve core clocks per machine cycle.
// Notes: Restarts at slot zero after reset.
`timescale 1ns/10ps
`default_nettype none
module irq_phase_timer #(
    parameter logic [irq_vec_pkg::PHASE_W-1:0] PERIOD = irq_vec_pkg::PHASES_PER_CYCLE
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    output logic [irq_vec_pkg::PHASE_W-1:0] slot,
    output logic state2_phase2,
    output logic state5_phase2,
    output logic poll_slot
);
    wire last_slot = (slot == PERIOD - 4'h1);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            slot <= '0;
        end else if (clk_en) begin
            slot <= last_slot ? '0 : slot + 4'h1;
        end
    end

    assign state2_phase2 = clk_en && (slot == irq_vec_pkg::SLOT_STATE2_PHASE2);
    assign state5_phase2 = clk_en && (slot == irq_vec_pkg::SLOT_STATE5_PHASE2);
    assign poll_slot = clk_en && (slot == irq_vec_pkg::SLOT_POLL);
endmodule : irq_phase_timer
`default_nettype wire

// [verification/irq_vectoring_properties.sv]
// Purpose: Port checks for the vectoring block.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound from the bench top file.
`timescale 1ns/10ps
`default_nettype none
module irq_vectoring_properties (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] irq_enable_reg,
    input wire logic ext0_request_flag,
    input wire logic timer0_overflow,
    input wire logic timer2_overflow_flag,
    input wire logic timer2_external_flag,
    input wire irq_vec_pkg::serial_flags_t serial_flags,
    input wire logic vector_ack,
    input wire irq_vec_pkg::vector_req_t vector_req,
    input wire logic [15:0] reset_vector,
    input wire logic timer0_overflow_flag
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_reset_vec_zero: assert property (reset_vector == irq_vec_pkg::VEC_RESET)
        else $error("reset vector not zero");
    a_vector_holds: assert property (vector_req.valid && !vector_ack |=> $stable(vector_req))
        else $error("vector changed before ack");
    a_ack_clears: assert property (vector_req.valid && vector_ack |=> !vector_req.valid)
        else $error("vector not cleared by ack");
    a_global_gate: assert property ($rose(vector_req.valid) |-> $past(irq_enable_reg[7]))
        else $error("vector with global enable off");
    a_ext0_vector: assert property ($rose(vector_req.valid) && vector_req.address == irq_vec_pkg::VEC_EXT0
        |-> $past(ext0_request_flag && irq_enable_reg[0])) else $error("ext0 vector without cause");
    a_tmr0_vector: assert property ($rose(vector_req.valid) && vector_req.address == irq_vec_pkg::VEC_TMR0
        |-> $past(timer0_overflow_flag && irq_enable_reg[1])) else $error("timer0 vector without cause");
    a_serial_vector: assert property ($rose(vector_req.valid) && vector_req.address == irq_vec_pkg::VEC_SER
        |-> $past(irq_enable_reg[4] && (serial_flags.uart_rx_done_flag || serial_flags.uart_tx_done_flag
        || (serial_flags.spi_done_flag && serial_flags.spi_irq_enable)))) else $error("serial vector without cause");
    a_tmr2_vector: assert property ($rose(vector_req.valid) && vector_req.address == irq_vec_pkg::VEC_TMR2
        |-> $past(irq_enable_reg[5] && (timer2_overflow_flag || timer2_external_flag)))
        else $error("timer2 vector without cause");
    a_tmr0_flag_set: assert property (timer0_overflow |-> ##[1:12] timer0_overflow_flag)
        else $error("timer0 flag not set in time");
endmodule : irq_vectoring_properties
`default_nettype wire

// [verification/core_ack_model.sv]
// Purpose: Core sequencer model taking vectors after a service latency.
// Assumes: The block holds its request until acknowledged.
// Notes: Acknowledge is a one-cycle pulse.
`timescale 1ns/10ps
`default_nettype none
module core_ack_model #(
    parameter int DELAY = 3
) (
    input wire logic ref_clk,
    input wire logic req_valid,
    output logic vector_ack
);
    int cnt = 0;
    initial vector_ack = 1'b0;
    always @(posedge ref_clk) begin
        vector_ack <= req_valid && cnt == DELAY && !vector_ack;
        cnt <= (req_valid && cnt < DELAY) ? cnt + 1 : 0;
    end
endmodule : core_ack_model
`default_nettype wire

// [verification/tb_mcu_interrupt_vectoring.sv]
// Purpose: Self-checking bench for the vectoring block.
// Assumes: Core clock 10 MHz; flags are levels, overflows pulses.
// Notes: Software-side flag clearing is done here.
`timescale 1ns/10ps
`default_nettype none
module tb_mcu_interrupt_vectoring;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] en = 8'h00;
    logic [9:0] src = 10'h000;
    logic [1:0] clr = 2'b00;
    logic ce = 1'b1;
    logic [5:0] pend;
    logic rsv;
    logic ack;
    irq_vec_pkg::vector_req_t vreq;
    logic [15:0] rvec;
    logic [1:0] tflag;
    int n_mismatch = 0;
    int compares = 0;
    always #50 ref_clk = ~ref_clk;
    irq_vectoring dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(ce), .irq_enable_reg(en),
        .ext0_request_flag(src[0]), .ext1_request_flag(src[2]), .timer0_overflow(src[1]),
        .timer1_overflow(src[3]), .timer0_clear(clr[0]), .timer1_clear(clr[1]),
        .timer2_overflow_flag(src[8]), .timer2_external_flag(src[9]), .vector_ack(ack),
        .serial_flags({src[4], src[5], src[6] | src[7], src[6]}), .vector_req(vreq), .pending(pend),
        .reset_vector(rvec), .timer0_overflow_flag(tflag[0]), .timer1_overflow_flag(tflag[1]),
        .reserved_write_seen(rsv));
    core_ack_model core (.ref_clk(ref_clk), .req_valid(vreq.valid), .vector_ack(ack));
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic run_case(input logic [9:0] s, input logic [7:0] e, input logic [15:0] exp);
        int n;
        logic [5:0] exp_pend;
        n = 0;
        // Requests that the rules let through: spi done counts only with its own enable (src[6])
        exp_pend = {s[9] | s[8], s[6] | s[5] | s[4], s[3], s[2], s[1], s[0]} & e[5:0] & {6{e[7]}};
        @(posedge ref_clk);
        src <= s;
        en <= e;
        @(posedge ref_clk);
        src[3:1] <= {1'b0, s[2], 1'b0};
        while (vreq.valid !== 1'b1 && n < 40) begin
            @(negedge ref_clk);
            n++;
        end
        cmp(vreq.valid === 1'b1 ? vreq.address : 16'hFFFF, exp);
        cmp({10'h000, pend}, {10'h000, exp_pend});
        repeat (8) @(negedge ref_clk);
        cmp({14'h0000, tflag}, {14'h0000, s[3], s[1]});
        cmp({15'h0000, rsv}, 16'h0000);
        @(posedge ref_clk);
        src <= 10'h000;
        en <= 8'h00;
        clr <= 2'b11;
        @(posedge ref_clk);
        clr <= 2'b00;
        repeat (16) @(posedge ref_clk);
    endtask : run_case
    task automatic t_reset();
        @(negedge ref_clk);
        cmp(rvec, irq_vec_pkg::VEC_RESET);
        cmp({15'h0000, vreq.valid}, 16'h0000);
        $display("test reset done");
    endtask : t_reset
    task automatic t_vectors();
        run_case(10'h001, 8'h81, irq_vec_pkg::VEC_EXT0);
        run_case(10'h002, 8'h82, irq_vec_pkg::VEC_TMR0);
        run_case(10'h004, 8'h84, irq_vec_pkg::VEC_EXT1);
        run_case(10'h008, 8'h88, irq_vec_pkg::VEC_TMR1);
        run_case(10'h010, 8'h90, irq_vec_pkg::VEC_SER);
        run_case(10'h020, 8'h90, irq_vec_pkg::VEC_SER);
        run_case(10'h040, 8'h90, irq_vec_pkg::VEC_SER);
        run_case(10'h100, 8'hA0, irq_vec_pkg::VEC_TMR2);
        run_case(10'h200, 8'hA0, irq_vec_pkg::VEC_TMR2);
        $display("test vectors done");
    endtask : t_vectors
    task automatic t_blocking();
        run_case(10'h080, 8'h90, 16'hFFFF);
        run_case(10'h040, 8'hAF, 16'hFFFF);
        run_case(10'h37F, 8'h3F, 16'hFFFF);
        run_case(10'h37F, 8'h80, 16'hFFFF);
        run_case(10'h101, 8'hA1, irq_vec_pkg::VEC_EXT0);
        $display("test blocking done");
    endtask : t_blocking
    task automatic t_freeze();
        @(posedge ref_clk);
        ce <= 1'b0;
        src <= 10'h001;
        en <= 8'h81;
        repeat (30) @(negedge ref_clk);
        cmp({15'h0000, vreq.valid}, 16'h0000);
        cmp({10'h000, pend}, 16'h0000);
        @(posedge ref_clk);
        ce <= 1'b1;
        run_case(10'h001, 8'h81, irq_vec_pkg::VEC_EXT0);
        $display("test freeze done");
    endtask : t_freeze
    task automatic give_verdict();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_vectors();
        t_blocking();
        t_freeze();
        give_verdict();
    end
    initial begin
        #500000;
        n_mismatch++;
        give_verdict();
    end
endmodule : tb_mcu_interrupt_vectoring
bind irq_vectoring irq_vectoring_properties chk (.ref_clk(ref_clk), .rst_n(rst_n),
    .irq_enable_reg(irq_enable_reg), .ext0_request_flag(ext0_request_flag),
    .timer0_overflow(timer0_overflow), .timer2_overflow_flag(timer2_overflow_flag),
    .timer2_external_flag(timer2_external_flag), .serial_flags(serial_flags),
    .vector_ack(vector_ack), .vector_req(vector_req), .reset_vector(reset_vector),
    .timer0_overflow_flag(timer0_overflow_flag));
`default_nettype wire
